// [logic/iod_device.sv]
// Purpose: Servo driver end: status reads, device set, I/O disable guard
// Assumes: Master sends header, then data characters, one per cycle max
// Notes: Set and guard commands carry hex characters after the header
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module iod_device import iod_pkg::*; (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Link
    iod_link_if.dev LINK,
    // Servo side inputs
    input wire logic [31:0] EXT_IN_DEV,
    input wire logic EMERGENCY_STOP,
    input wire logic [15:0] ANALOG_IN,
    input wire logic PULSE_IN,
    input wire logic [31:0] OUT_DEV_STATE,
    input wire logic [6:0] OUT_PIN_STATE,
    // Effective state toward servo logic
    output logic [31:0] IN_DEV_EFF,
    output logic EMERGENCY_STOP_EFF,
    output logic [15:0] ANALOG_EFF,
    output logic PULSE_EFF,
    output logic [31:0] OUT_DEV_EFF,
    output logic [31:0] COMM_SET_WORD,
    output logic IN_DISABLED,
    output logic OUT_DISABLED
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_RECV = 2'b01, ST_SEND = 2'b11
    } iod_dst_t;

    function automatic logic [3:0] hex2nib(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) return 4'(c - 8'h30);
        if (c >= 8'h41 && c <= 8'h46) return 4'(c - 8'h37);
        if (c >= 8'h61 && c <= 8'h66) return 4'(c - 8'h57);
        return 4'h0;
    endfunction

    function automatic logic [7:0] nib2hex(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    // Pin inputs cross in through two flops
    logic [31:0] ext_s1_r, ext_s2_r;
    logic emg_s1_r, emg_s2_r, pls_s1_r, pls_s2_r;
    logic [15:0] ana_s1_r, ana_s2_r;
    logic [31:0] odv_s1_r, odv_s2_r;
    logic [6:0] opn_s1_r, opn_s2_r;
    always_ff @(posedge MCLK) begin
        ext_s1_r <= EXT_IN_DEV;
        ext_s2_r <= ext_s1_r;
        emg_s1_r <= EMERGENCY_STOP;
        emg_s2_r <= emg_s1_r;
        pls_s1_r <= PULSE_IN;
        pls_s2_r <= pls_s1_r;
        ana_s1_r <= ANALOG_IN;
        ana_s2_r <= ana_s1_r;
        odv_s1_r <= OUT_DEV_STATE;
        odv_s2_r <= odv_s1_r;
        opn_s1_r <= OUT_PIN_STATE;
        opn_s2_r <= opn_s1_r;
    end

    iod_dst_t state_r, state_nxt;
    logic [7:0] code_r, dnum_r;
    logic [31:0] shift_r, shift_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [31:0] set_r, set_nxt;
    logic in_dis_r, in_dis_nxt, out_dis_r, out_dis_nxt;

    wire logic is_read = LINK.cmd_code == CMD_STATUS_READ;
    wire logic [31:0] in_word = set_r & IN_DEV_MASK;
    wire logic [31:0] pin_word = {25'h0, opn_s2_r};
    wire logic [31:0] odev_word = odv_s2_r & OUT_DEV_MASK;
    wire logic [31:0] read_word =
        (LINK.cmd_dnum == DN_IN_DEV) ? in_word :
        (LINK.cmd_dnum == DN_OUT_PIN) ? pin_word :
        (LINK.cmd_dnum == DN_OUT_DEV) ? odev_word : 32'h0;
    wire logic [31:0] rx_word = {shift_r[27:0], hex2nib(LINK.cmd_char)};
    wire logic guard_ok = rx_word[15:0] == GUARD_WORD;
    wire logic rx_done = LINK.cmd_char_valid &&
        cnt_r == 4'(NIBBLES - 1);

    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        set_nxt = set_r;
        in_dis_nxt = in_dis_r;
        out_dis_nxt = out_dis_r;
        unique case (state_r)
            ST_IDLE: begin
                cnt_nxt = 4'h0;
                if (LINK.cmd_valid && is_read) begin
                    shift_nxt = read_word;
                    state_nxt = ST_SEND;
                end else if (LINK.cmd_valid) begin
                    shift_nxt = 32'h0;
                    state_nxt = ST_RECV;
                end
            end
            ST_RECV: begin
                if (LINK.cmd_char_valid) begin
                    shift_nxt = rx_word;
                    cnt_nxt = cnt_r + 4'h1;
                end
                if (rx_done) begin
                    state_nxt = ST_IDLE;
                    if (code_r == CMD_DEV_SET && dnum_r == DN_IN_DEV)
                        set_nxt = rx_word & IN_DEV_MASK;
                    if (code_r == CMD_IO_GUARD && guard_ok) begin
                        if (dnum_r == DN_IN_DISABLE) in_dis_nxt = 1'b1;
                        if (dnum_r == DN_IN_ENABLE) in_dis_nxt = 1'b0;
                        if (dnum_r == DN_OUT_DISABLE) out_dis_nxt = 1'b1;
                        if (dnum_r == DN_OUT_ENABLE) out_dis_nxt = 1'b0;
                    end
                end
            end
            ST_SEND: begin
                shift_nxt = {shift_r[27:0], 4'h0};
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == 4'(NIBBLES - 1)) state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            state_r <= ST_IDLE;
            shift_r <= 32'h0;
            cnt_r <= 4'h0;
            set_r <= DEV_SET_RST;
            in_dis_r <= 1'b0;
            out_dis_r <= 1'b0;
            code_r <= 8'h0;
            dnum_r <= 8'h0;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            set_r <= set_nxt;
            in_dis_r <= in_dis_nxt;
            out_dis_r <= out_dis_nxt;
            if (state_r == ST_IDLE && LINK.cmd_valid) begin
                code_r <= LINK.cmd_code;
                dnum_r <= LINK.cmd_dnum;
            end
        end
    end

    assign LINK.cmd_busy = state_r != ST_IDLE;
    assign LINK.rsp_valid = state_r == ST_SEND;
    assign LINK.rsp_char = nib2hex(shift_r[31:28]);
    assign LINK.rsp_last = state_r == ST_SEND &&
        cnt_r == 4'(NIBBLES - 1);

    // Stored set word stays put while inputs are disabled
    wire logic [31:0] merged_in = ext_s2_r | set_r;
    wire logic [31:0] keep_mask =
        (32'h1 << IN_FWD_STROKE_BIT) | (32'h1 << IN_REV_STROKE_BIT);
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            IN_DEV_EFF <= 32'h0;
            EMERGENCY_STOP_EFF <= 1'b0;
            ANALOG_EFF <= 16'h0;
            PULSE_EFF <= 1'b0;
            OUT_DEV_EFF <= 32'h0;
        end else begin
            IN_DEV_EFF <= in_dis_r ? (merged_in & keep_mask)
                                   : merged_in;
            EMERGENCY_STOP_EFF <= emg_s2_r;
            ANALOG_EFF <= in_dis_r ? 16'h0 : ana_s2_r;
            PULSE_EFF <= in_dis_r ? 1'b0 : pls_s2_r;
            OUT_DEV_EFF <= out_dis_r ? 32'h0 : odv_s2_r;
        end
    end
    assign COMM_SET_WORD = set_r;
    assign IN_DISABLED = in_dis_r;
    assign OUT_DISABLED = out_dis_r;
endmodule // iod_device

// [shared/iod_pkg.sv]
// Purpose: Shared constants for the I/O diagnosis command link
// Assumes: One clock, synchronous active-low reset on both ends
// Notes: Command codes and data numbers are byte values on the link
package iod_pkg;
    localparam logic [7:0] CMD_STATUS_READ = 8'h12;
    localparam logic [7:0] CMD_DEV_SET = 8'h92;
    localparam logic [7:0] CMD_IO_GUARD = 8'h90;
    localparam logic [7:0] DN_IN_DEV = 8'h60;
    localparam logic [7:0] DN_OUT_PIN = 8'hc0;
    localparam logic [7:0] DN_OUT_DEV = 8'h80;
    localparam logic [7:0] DN_IN_DISABLE = 8'h00;
    localparam logic [7:0] DN_IN_ENABLE = 8'h10;
    localparam logic [7:0] DN_OUT_DISABLE = 8'h03;
    localparam logic [7:0] DN_OUT_ENABLE = 8'h13;
    localparam logic [15:0] GUARD_WORD = 16'h1ea5;
    localparam int NIBBLES = 8;
    // Layout of the communication-set input device word
    localparam logic [31:0] IN_DEV_MASK = 32'h0810_ffff;
    localparam int IN_FWD_STROKE_BIT = 1;
    localparam int IN_REV_STROKE_BIT = 2;
    // Layout of the output device word
    localparam logic [31:0] OUT_DEV_MASK = 32'h0a00_f7bf;
    localparam logic [31:0] OUT_PIN_MASK = 32'h0000_007f;
    localparam logic [31:0] DEV_SET_RST = 32'h0000_0000;
    // Host register map, byte addresses
    localparam logic [7:0] HR_CTRL = 8'h00;
    localparam logic [7:0] HR_DATA = 8'h04;
    localparam logic [7:0] HR_RESULT = 8'h08;
    localparam logic [7:0] HR_STATUS = 8'h0c;
    localparam logic [7:0] HR_IRQ_STAT = 8'h10;
    localparam logic [7:0] HR_IRQ_MASK = 8'h14;
    localparam logic [1:0] IRQ_DONE_BIT = 2'd0;
    localparam logic [1:0] IRQ_BAD_BIT = 2'd1;
endpackage

// [shared/iod_link_if.sv]
// Purpose: Link between master station and servo driver command handler
// Assumes: Common clock; one command in flight at a time
// Notes: Replies are eight hex characters, most significant first
`timescale 1ns/1ns
interface iod_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [7:0] cmd_dnum;
    logic [7:0] cmd_char;
    logic cmd_char_valid;
    logic cmd_busy;
    logic rsp_valid;
    logic [7:0] rsp_char;
    logic rsp_last;
    modport dev (input cmd_valid, cmd_code, cmd_dnum, cmd_char,
                 cmd_char_valid, output cmd_busy, rsp_valid, rsp_char,
                 rsp_last);
    modport mst (output cmd_valid, cmd_code, cmd_dnum, cmd_char,
                 cmd_char_valid, input cmd_busy, rsp_valid, rsp_char,
                 rsp_last);
endinterface

// [logic/iod_master.sv]
// Purpose: Master station end driven by software over AHB-Lite
// Assumes: Single word transfers, OKAY response, zero wait states
// Notes: Writing CTRL while idle launches one command; DATA is sent as hex
`timescale 1ns/1ns
module iod_master import iod_pkg::*; (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // Interrupt
    output logic IRQ,
    // Link
    iod_link_if.mst LINK
);
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00, MS_HDR = 2'b01, MS_DATA = 2'b11, MS_WAIT = 2'b10
    } iod_mst_t;

    function automatic logic [7:0] nib2hex(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction
    function automatic logic [3:0] hex2nib(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) return 4'(c - 8'h30);
        if (c >= 8'h41 && c <= 8'h46) return 4'(c - 8'h37);
        return 4'(c - 8'h57);
    endfunction

    iod_mst_t st_r;
    logic wr_pend_r;
    logic [7:0] addr_r;
    logic [15:0] ctrl_r;
    logic [31:0] data_r, tx_r, result_r, rdata_r;
    logic [3:0] cnt_r;
    logic [1:0] ist_r, imask_r;

    wire logic aphase = HSEL && HREADY && HTRANS[1];
    wire logic wr_ctrl = wr_pend_r && addr_r == HR_CTRL;
    wire logic start = wr_ctrl && st_r == MS_IDLE;
    wire logic bad = wr_ctrl && st_r != MS_IDLE;
    wire logic done = LINK.rsp_valid && LINK.rsp_last;
    wire logic [1:0] ev = {bad, done};
    wire logic [31:0] rd_mux =
        (HADDR == HR_CTRL) ? {16'h0, ctrl_r} :
        (HADDR == HR_DATA) ? data_r :
        (HADDR == HR_RESULT) ? result_r :
        (HADDR == HR_STATUS) ? {31'h0, st_r != MS_IDLE} :
        (HADDR == HR_IRQ_STAT) ? {30'h0, ist_r} :
        (HADDR == HR_IRQ_MASK) ? {30'h0, imask_r} : 32'h0;

    // Read data captured at the address phase, so a read issued
    // back to back with a write to the same register sees the old value
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h0;
            rdata_r <= 32'h0;
        end else begin
            wr_pend_r <= aphase && HWRITE && HSIZE == 3'd2;
            if (aphase) addr_r <= HADDR;
            if (aphase) rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            ctrl_r <= 16'h0;
            data_r <= 32'h0;
            imask_r <= 2'b00;
            ist_r <= 2'b00;
        end else begin
            if (start) ctrl_r <= HWDATA[15:0];
            if (wr_pend_r && addr_r == HR_DATA) data_r <= HWDATA;
            if (wr_pend_r && addr_r == HR_IRQ_MASK) imask_r <= HWDATA[1:0];
            // Set wins over a same-cycle clear
            ist_r <= (wr_pend_r && addr_r == HR_IRQ_STAT ?
                      ist_r & ~HWDATA[1:0] : ist_r) | ev;
        end
    end

    // Link sequencer: header, then eight data characters or a reply
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            st_r <= MS_IDLE;
            tx_r <= 32'h0;
            cnt_r <= 4'h0;
            result_r <= 32'h0;
        end else begin
            unique case (st_r)
                MS_IDLE: if (start) st_r <= MS_HDR;
                MS_HDR: begin
                    tx_r <= data_r;
                    cnt_r <= 4'h0;
                    st_r <= (ctrl_r[15:8] == CMD_STATUS_READ) ?
                            MS_WAIT : MS_DATA;
                end
                MS_DATA: begin
                    tx_r <= {tx_r[27:0], 4'h0};
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'(NIBBLES - 1)) st_r <= MS_IDLE;
                end
                MS_WAIT: if (LINK.rsp_valid) begin
                    result_r <= {result_r[27:0],
                                 hex2nib(LINK.rsp_char)};
                    if (LINK.rsp_last) st_r <= MS_IDLE;
                end
            endcase
        end
    end

    assign LINK.cmd_valid = st_r == MS_HDR;
    assign LINK.cmd_code = ctrl_r[15:8];
    assign LINK.cmd_dnum = ctrl_r[7:0];
    assign LINK.cmd_char_valid = st_r == MS_DATA;
    assign LINK.cmd_char = nib2hex(tx_r[31:28]);
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_r;
    assign IRQ = |(ist_r & imask_r);
endmodule // iod_master

// [dv/iod_link_properties.sv]
// Purpose: Protocol checks on the link between master and device ends
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only the interface signals, instantiated beside the link
`timescale 1ns/1ns
module iod_link_properties import iod_pkg::*; (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Link signals
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_dnum,
    input wire logic [7:0] cmd_char,
    input wire logic cmd_char_valid,
    input wire logic cmd_busy,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_char,
    input wire logic rsp_last
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    wire rd_hdr = cmd_valid && cmd_code == CMD_STATUS_READ;
    function automatic logic is_hex(logic [7:0] c);
        return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction
    read_reply_a: assert property (rd_hdr |=> rsp_valid [*8])
        else $error("read reply is not eight characters");
    last_char_a: assert property (rd_hdr |-> ##8 rsp_last)
        else $error("last flag missing on eighth character");
    last_span_a: assert property (
        rsp_last |-> rsp_valid && $past(rsp_valid, 7))
        else $error("last flag without a full reply");
    hex_char_a: assert property (rsp_valid |-> is_hex(rsp_char))
        else $error("reply character is not hex");
    pin_word_a: assert property (
        rd_hdr && cmd_dnum == DN_OUT_PIN |=> (rsp_char == 8'h30) [*6]
        ##1 rsp_char <= 8'h37)
        else $error("output pin word has unused bits set");
    in_word_a: assert property (
        rd_hdr && cmd_dnum == DN_IN_DEV |=> rsp_char == 8'h30
        ##1 rsp_char inside {8'h30, 8'h38} ##1 rsp_char inside {8'h30, 8'h31})
        else $error("input word has unused bits set");
    out_word_a: assert property (
        rd_hdr && cmd_dnum == DN_OUT_DEV |=> rsp_char == 8'h30
        ##1 rsp_char inside {8'h30, 8'h32, 8'h38, 8'h41}
        ##1 rsp_char == 8'h30 ##1 rsp_char == 8'h30 ##2 rsp_char <= 8'h37)
        else $error("output device word has unused bits set");
    no_overlap_a: assert property (rsp_valid |-> !cmd_valid)
        else $error("header sent during a reply");
    set_char_a: assert property (cmd_char_valid |-> is_hex(cmd_char))
        else $error("data character is not hex");
    set_len_a: assert property (
        cmd_valid && cmd_code != CMD_STATUS_READ |=> cmd_char_valid [*8])
        else $error("set or guard data is not eight characters");
    busy_hdr_a: assert property (cmd_valid |=> cmd_busy)
        else $error("device not busy after a header");
    hdr_idle_a: assert property (cmd_valid |-> !cmd_busy)
        else $error("header sent while the device is busy");
    busy_end_a: assert property (rsp_last |=> !cmd_busy)
        else $error("device still busy after the last reply character");
    cover property (rsp_last);
    cover property (cmd_valid && cmd_code == CMD_DEV_SET);
    cover property (cmd_valid && cmd_code == CMD_IO_GUARD);
endmodule // iod_link_properties

// [dv/tb_io_diag_override_cmd_handler.sv]
// Purpose: Drives software commands through master into device end
// Assumes: Zero wait AHB-Lite slave, one command in flight
// Notes: Expected words follow the documented bit layouts
`timescale 1ns/1ns
module tb_io_diag_override_cmd_handler import iod_pkg::*;;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] ext_in = 32'h0;
    logic estop = 1'b1;
    logic [15:0] analog = 16'h1234;
    logic pulse = 1'b1;
    logic [31:0] out_st = 32'hffff_ffff;
    logic [6:0] pin_st = 7'h55;
    wire hready, hresp, irq, estop_eff, pulse_eff, in_dis, out_dis;
    wire [31:0] hrdata, in_eff, out_eff, set_word;
    wire [15:0] analog_eff;
    int n_fail = 0;
    int n_tests = 0;
    int n_cyc = 0;
    logic [31:0] q;
    iod_link_if link();
    iod_master u_iod_master (.MCLK(mclk), .RESETN(resetn), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
        .HRESP(hresp), .HRDATA(hrdata), .IRQ(irq), .LINK(link.mst));
    iod_device u_iod_device (.MCLK(mclk), .RESETN(resetn), .LINK(link.dev),
        .EXT_IN_DEV(ext_in), .EMERGENCY_STOP(estop), .ANALOG_IN(analog),
        .PULSE_IN(pulse), .OUT_DEV_STATE(out_st), .OUT_PIN_STATE(pin_st),
        .IN_DEV_EFF(in_eff), .EMERGENCY_STOP_EFF(estop_eff),
        .ANALOG_EFF(analog_eff), .PULSE_EFF(pulse_eff), .OUT_DEV_EFF(out_eff),
        .COMM_SET_WORD(set_word), .IN_DISABLED(in_dis),
        .OUT_DISABLED(out_dis));
    iod_link_properties u_iod_link_properties (.MCLK(mclk), .RESETN(resetn),
        .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .cmd_dnum(link.cmd_dnum), .cmd_char(link.cmd_char),
        .cmd_char_valid(link.cmd_char_valid), .cmd_busy(link.cmd_busy),
        .rsp_valid(link.rsp_valid), .rsp_char(link.rsp_char),
        .rsp_last(link.rsp_last));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Address phase held until hready, read data taken at data phase edge
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge mclk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Launch one command and poll busy; the timeout bounds the poll
    task automatic cmd(logic [7:0] c, logic [7:0] n, logic [31:0] d);
        ahb(1'b1, HR_DATA, d);
        ahb(1'b1, HR_CTRL, {16'h0, c, n});
        q = 32'h1;
        while (q[0] !== 1'b0) ahb(1'b0, HR_STATUS, 32'h0);
        // Effective outputs lag the stored word by one cycle
        repeat (3) @(posedge mclk);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        n_cyc++;
        if (n_cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        ahb(1'b0, HR_STATUS, 32'h0);
        check("status", q, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        ahb(1'b0, 8'h20, 32'h0);
        check("unmapped", q, 32'h0);
        cmd(CMD_DEV_SET, DN_IN_DEV, 32'h0810_a5c7);
        check("set word", set_word, 32'h0810_a5c7);
        check("in eff", in_eff, 32'h0810_a5c7);
        cmd(CMD_STATUS_READ, DN_IN_DEV, 32'h0);
        ahb(1'b0, HR_RESULT, 32'h0);
        check("in read", q, 32'h0810_a5c7);
        cmd(CMD_IO_GUARD, DN_IN_DISABLE, 32'h0000_1ea4);
        check("in dis bad", {31'h0, in_dis}, 32'h0);
        cmd(CMD_IO_GUARD, DN_IN_DISABLE, {16'h0, GUARD_WORD});
        check("in dis", {31'h0, in_dis}, 32'h1);
        check("kept word", set_word, 32'h0810_a5c7);
        check("in eff dis", in_eff, 32'h0000_0006);
        check("analog dis", {16'h0, analog_eff}, 32'h0);
        check("pulse dis", {31'h0, pulse_eff}, 32'h0);
        check("estop", {31'h0, estop_eff}, 32'h1);
        cmd(CMD_IO_GUARD, DN_IN_ENABLE, {16'h0, GUARD_WORD});
        check("in en", {31'h0, in_dis}, 32'h0);
        check("analog en", {16'h0, analog_eff}, 32'h1234);
        check("pulse en", {31'h0, pulse_eff}, 32'h1);
        cmd(CMD_DEV_SET, DN_IN_DEV, 32'h0000_0001);
        check("replaced", set_word, 32'h0000_0001);
        // External input still holds a device that comm switched off
        ext_in <= 32'h0000_0101;
        cmd(CMD_DEV_SET, DN_IN_DEV, 32'h0000_0000);
        check("ext held", in_eff, 32'h0000_0101);
        ext_in <= 32'h0;
        repeat (4) @(posedge mclk);
        check("ext off", in_eff, 32'h0);
        cmd(CMD_STATUS_READ, DN_OUT_DEV, 32'h0);
        ahb(1'b0, HR_RESULT, 32'h0);
        check("out dev", q, 32'h0a00_f7bf);
        cmd(CMD_STATUS_READ, DN_OUT_PIN, 32'h0);
        ahb(1'b0, HR_RESULT, 32'h0);
        check("out pin", q, 32'h0000_0055);
        cmd(CMD_IO_GUARD, DN_OUT_DISABLE, 32'h0);
        check("out dis bad", {31'h0, out_dis}, 32'h0);
        cmd(CMD_IO_GUARD, DN_OUT_DISABLE, {16'h0, GUARD_WORD});
        check("out dis", {31'h0, out_dis}, 32'h1);
        check("out eff dis", out_eff, 32'h0);
        cmd(CMD_IO_GUARD, DN_OUT_ENABLE, {16'h0, GUARD_WORD});
        check("out en", {31'h0, out_dis}, 32'h0);
        check("out eff en", out_eff, 32'hffff_ffff);
        // Second launch lands while busy and must be refused
        ahb(1'b1, HR_IRQ_STAT, 32'h3);
        ahb(1'b1, HR_CTRL, {16'h0, CMD_STATUS_READ, DN_IN_DEV});
        cmd(CMD_STATUS_READ, DN_IN_DEV, 32'h0);
        ahb(1'b0, HR_IRQ_STAT, 32'h0);
        check("irq stat", q, 32'h3);
        check("irq masked", {31'h0, irq}, 32'h0);
        ahb(1'b1, HR_IRQ_MASK, 32'h2);
        // Mask lands at the data phase edge; look one cycle later
        @(posedge mclk);
        check("irq on", {31'h0, irq}, 32'h1);
        ahb(1'b1, HR_IRQ_STAT, 32'h2);
        ahb(1'b0, HR_IRQ_STAT, 32'h0);
        check("irq cleared", q, 32'h1);
        check("irq off", {31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule // tb_io_diag_override_cmd_handler
